// ===== mesc_defines.svh
// Register offsets, field positions and limits of the error statistics counters
`ifndef MESC_DEFINES_SVH
`define MESC_DEFINES_SVH

// Counter indices
`define MESC_ALIGN_IDX 0
`define MESC_DEFER_IDX 1
`define MESC_LATE_IDX 2
`define MESC_EXCESS_IDX 3
`define MESC_UNDER_IDX 4
`define MESC_CARRIER_IDX 5
`define MESC_NOBUF_IDX 6
`define MESC_OVERRUN_IDX 7
`define MESC_NCNT 8
`define MESC_CW 16

// Counter widths
`define MESC_W_ALIGN 8
`define MESC_W_DEFER 16
`define MESC_W_LATE 8
`define MESC_W_EXCESS 8
`define MESC_W_UNDER 8
`define MESC_W_CARRIER 8
`define MESC_W_NOBUF 16
`define MESC_W_OVERRUN 8

// Byte offsets
`define MESC_AW 8
`define MESC_OFS_ALIGN 8'h00
`define MESC_OFS_DEFER 8'h04
`define MESC_OFS_LATE 8'h08
`define MESC_OFS_EXCESS 8'h0c
`define MESC_OFS_UNDER 8'h10
`define MESC_OFS_CARRIER 8'h14
`define MESC_OFS_NOBUF 8'h18
`define MESC_OFS_OVERRUN 8'h1c
`define MESC_OFS_STAT 8'h20
`define MESC_OFS_CLR 8'h24
`define MESC_OFS_EN 8'h28
`define MESC_OFS_CTRL 8'h2c

// Control register bit positions
`define MESC_CTRL_DUPLEX 0
`define MESC_CTRL_RXEN 3
`define MESC_CTRL_STWE 7
`define MESC_CTRL_BIG 8

// Frame length limits in bytes
`define MESC_LW 11
`define MESC_MIN_LEN 11'd64
`define MESC_MAX_LEN 11'd1518
`define MESC_MAX_LEN_BIG 11'd1536
`define MESC_COLW 5

`endif

// ===== mesc_pkg.sv
// Types shared by the error statistics counter block
`include "mesc_defines.svh"
package mesc_pkg;
   // Receive frame report, one-cycle valid
   typedef struct packed {
      logic done;
      logic len_odd;
      logic crc_bad;
      logic symbol_err;
      logic [`MESC_LW-1:0] len;
      logic addr_match;
      logic no_buffer;
      logic overrun;
   } mesc_rx_rpt_s;

   // Transmit frame report, one-cycle valid
   typedef struct packed {
      logic done;
      logic deferred;
      logic [`MESC_COLW-1:0] collisions;
      logic late_col;
      logic excess_col;
      logic underrun;
      logic crs_seen;
      logic crs_dropped;
   } mesc_tx_rpt_s;

   // Register access toward the register file
   typedef struct packed {
      logic valid;
      logic write;
      logic [`MESC_AW-1:0] addr;
      logic [31:0] wdata;
   } mesc_breq_s;

   typedef struct packed {
      logic pend;
      logic write;
      logic in_range;
      logic [`MESC_AW-1:0] addr;
      logic [31:0] rdata;
   } mesc_ahb_s;

   typedef struct packed {
      logic [`MESC_CW-1:0] cnt;
   } mesc_cnt_s;

   typedef struct packed {
      logic [`MESC_NCNT-1:0] ev;
      logic col_pulse;
      logic [`MESC_NCNT-1:0] status;
      logic [`MESC_NCNT-1:0] enable;
      logic duplex;
      logic rx_en;
      logic stat_we;
      logic big_frames;
   } mesc_main_s;
endpackage : mesc_pkg

// ===== mesc_ahb_slave.sv
// AHB-Lite slave front end with one wait state for every transfer
`timescale 1ns/1ps
module mesc_ahb_slave
   import mesc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Register file side
   output mesc_breq_s breq,
   input wire logic [31:0] reg_rdata
);
   mesc_ahb_s st;
   mesc_ahb_s next_st;
   logic take;

   // Only whole-word transfers are expected; hsize is not checked
   assign take = hsel & htrans[1] & hready & !st.pend;

   always_comb begin
      next_st = st;
      if (take) begin
         next_st.pend = 1'b1;
         next_st.write = hwrite;
         next_st.in_range = (haddr[31:`MESC_AW] == '0);
         next_st.addr = haddr[`MESC_AW-1:0];
      end else if (st.pend) begin
         next_st.pend = 1'b0;
         next_st.rdata = (st.write || !st.in_range) ? 32'h0000_0000 : reg_rdata;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign breq.valid = st.pend & st.in_range;
   assign breq.write = st.write;
   assign breq.addr = st.addr;
   assign breq.wdata = hwdata;
   assign hreadyout = !st.pend;
   assign hresp = 1'b0;
   assign hrdata = st.rdata;
endmodule : mesc_ahb_slave

// ===== mesc_sat_counter.sv
// Saturating statistics counter with clear on read and gated write
`timescale 1ns/1ps
module mesc_sat_counter
   import mesc_pkg::*;
#(
   parameter int WIDTH = 8
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // Control
   input wire logic inc,
   input wire logic rd_clr,
   input wire logic wr,
   input wire logic [`MESC_CW-1:0] wdata,
   // Value
   output logic [`MESC_CW-1:0] count
);
   localparam logic [`MESC_CW-1:0] MASK = `MESC_CW'((1 << WIDTH) - 1);
   mesc_cnt_s st;
   mesc_cnt_s next_st;
   logic [`MESC_CW-1:0] base;

   always_comb begin
      next_st = st;
      base = st.cnt;
      if (wr) begin
         next_st.cnt = wdata & MASK;
      end else begin
         base = rd_clr ? '0 : st.cnt;
         if (inc && base != MASK) begin
            base = base + `MESC_CW'(1);
         end
         next_st.cnt = base;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign count = st.cnt & MASK;
endmodule : mesc_sat_counter

// ===== mesc_stat_counters.sv
// Error statistics counters of the MAC with AHB-Lite register access and interrupt
`timescale 1ns/1ps
// Operation
// - Count odd-bit frames of valid length with bad truncated CRC as alignment errors.
// - Symbol error in valid-length odd-bit frame also counts as alignment error.
// - 16-bit counter of frames deferred on first attempt by carrier sense.
// - Deferred count ignores frames with any collision or underrun.
// - 8-bit counter of frames colliding after the 512-bit slot time.
// - Late collision also credited to ordinary collision statistics.
// - 8-bit counter of frames abandoned after 16 collisions.
// - 8-bit counter of frames lost to transmit DMA underrun.
// - An underrun frame advances no other counter.
// - 8-bit counter of clean frames where carrier was missing or dropped.
// - Carrier error counted only in half duplex.
// - Carrier error affects nothing but its own counter.
// - 16-bit counter of matched frames dropped for lack of receive buffer.
// - 8-bit counter of recognised frames lost to receive DMA overrun.
// - Counters clear on read and saturate at all ones.
// - Receive counters advance only while receive is enabled.
// - Counter writes take effect only with statistics write enable set.
module mesc_stat_counters
   import mesc_pkg::*;
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // AHB-Lite
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // Frame reports from the MAC datapath
   input mesc_rx_rpt_s rx_rpt,
   input mesc_tx_rpt_s tx_rpt,
   // Toward the ordinary collision statistics
   output logic collision_credit,
   // Interrupt
   output logic irq
);
   mesc_main_s st;
   mesc_main_s next_st;
   mesc_breq_s breq;
   logic [31:0] reg_rdata;
   logic [`MESC_NCNT-1:0] inc;
   logic [`MESC_NCNT-1:0] rd_clr;
   logic [`MESC_NCNT-1:0] cnt_wr;
   logic [`MESC_NCNT-1:0][`MESC_CW-1:0] counts;
   logic rx_len_ok;
   logic tx_clean;
   logic tx_ok;
   logic wr_op;
   logic rd_op;

   // Offset of a counter index
   function automatic logic [`MESC_AW-1:0] cnt_ofs(input int idx);
      case (idx)
         `MESC_ALIGN_IDX: cnt_ofs = `MESC_OFS_ALIGN;
         `MESC_DEFER_IDX: cnt_ofs = `MESC_OFS_DEFER;
         `MESC_LATE_IDX: cnt_ofs = `MESC_OFS_LATE;
         `MESC_EXCESS_IDX: cnt_ofs = `MESC_OFS_EXCESS;
         `MESC_UNDER_IDX: cnt_ofs = `MESC_OFS_UNDER;
         `MESC_CARRIER_IDX: cnt_ofs = `MESC_OFS_CARRIER;
         `MESC_NOBUF_IDX: cnt_ofs = `MESC_OFS_NOBUF;
         default: cnt_ofs = `MESC_OFS_OVERRUN;
      endcase
   endfunction : cnt_ofs

   // Width of a counter index
   function automatic int cnt_width(input int idx);
      case (idx)
         `MESC_ALIGN_IDX: cnt_width = `MESC_W_ALIGN;
         `MESC_DEFER_IDX: cnt_width = `MESC_W_DEFER;
         `MESC_LATE_IDX: cnt_width = `MESC_W_LATE;
         `MESC_EXCESS_IDX: cnt_width = `MESC_W_EXCESS;
         `MESC_UNDER_IDX: cnt_width = `MESC_W_UNDER;
         `MESC_CARRIER_IDX: cnt_width = `MESC_W_CARRIER;
         `MESC_NOBUF_IDX: cnt_width = `MESC_W_NOBUF;
         default: cnt_width = `MESC_W_OVERRUN;
      endcase
   endfunction : cnt_width

   // Length window, extended when large frames are allowed
   function automatic logic len_valid(input logic [`MESC_LW-1:0] len, input logic big);
      logic [`MESC_LW-1:0] max_len;
      max_len = big ? `MESC_MAX_LEN_BIG : `MESC_MAX_LEN;
      len_valid = (len >= `MESC_MIN_LEN) && (len <= max_len);
   endfunction : len_valid

   mesc_ahb_slave u_ahb (
      .core_clk(core_clk),
      .rst(rst),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hwdata(hwdata),
      .hready(hready),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .breq(breq),
      .reg_rdata(reg_rdata)
   );

   assign wr_op = breq.valid & breq.write;
   assign rd_op = breq.valid & !breq.write;

   // Frame classification
   always_comb begin
      rx_len_ok = len_valid(rx_rpt.len, st.big_frames);
      tx_clean = (tx_rpt.collisions == '0) && !tx_rpt.late_col && !tx_rpt.excess_col;
      tx_ok = tx_rpt.done && !tx_rpt.underrun;
      inc = '0;
      inc[`MESC_ALIGN_IDX] = rx_rpt.done && st.rx_en && rx_rpt.len_odd && rx_len_ok &&
                           (rx_rpt.crc_bad || rx_rpt.symbol_err);
      inc[`MESC_DEFER_IDX] = tx_ok && tx_rpt.deferred && tx_clean;
      inc[`MESC_LATE_IDX] = tx_ok && tx_rpt.late_col;
      inc[`MESC_EXCESS_IDX] = tx_ok && tx_rpt.excess_col;
      inc[`MESC_UNDER_IDX] = tx_rpt.done && tx_rpt.underrun;
      inc[`MESC_CARRIER_IDX] = tx_ok && tx_clean && !st.duplex &&
                           (!tx_rpt.crs_seen || tx_rpt.crs_dropped);
      inc[`MESC_NOBUF_IDX] = rx_rpt.done && st.rx_en && rx_rpt.addr_match && rx_rpt.no_buffer;
      inc[`MESC_OVERRUN_IDX] = rx_rpt.done && st.rx_en && rx_rpt.addr_match && rx_rpt.overrun;
   end

   // Register decode
   always_comb begin
      rd_clr = '0;
      cnt_wr = '0;
      for (int i = 0; i < `MESC_NCNT; i++) begin
         rd_clr[i] = rd_op && (breq.addr == cnt_ofs(i));
         cnt_wr[i] = wr_op && st.stat_we && (breq.addr == cnt_ofs(i));
      end
   end

   generate
      for (genvar g = 0; g < `MESC_NCNT; g++) begin : g_cnt
         mesc_sat_counter #(
            .WIDTH(cnt_width(g))
         ) u_cnt (
            .core_clk(core_clk),
            .rst(rst),
            .inc(inc[g]),
            .rd_clr(rd_clr[g]),
            .wr(cnt_wr[g]),
            .wdata(breq.wdata[`MESC_CW-1:0]),
            .count(counts[g])
         );
      end
   endgenerate

   // Read data; unused upper bits and unmapped offsets read zero
   always_comb begin
      reg_rdata = 32'h0000_0000;
      for (int i = 0; i < `MESC_NCNT; i++) begin
         if (breq.addr == cnt_ofs(i)) begin
            reg_rdata = {{(32 - `MESC_CW){1'b0}}, counts[i]};
         end
      end
      case (breq.addr)
         `MESC_OFS_STAT: reg_rdata = {{(32 - `MESC_NCNT){1'b0}}, st.status};
         `MESC_OFS_EN: reg_rdata = {{(32 - `MESC_NCNT){1'b0}}, st.enable};
         `MESC_OFS_CTRL: begin
            reg_rdata[`MESC_CTRL_DUPLEX] = st.duplex;
            reg_rdata[`MESC_CTRL_RXEN] = st.rx_en;
            reg_rdata[`MESC_CTRL_STWE] = st.stat_we;
            reg_rdata[`MESC_CTRL_BIG] = st.big_frames;
         end
         default: begin
         end
      endcase
   end

   // State update
   always_comb begin
      next_st = st;
      next_st.ev = inc;
      next_st.col_pulse = inc[`MESC_LATE_IDX];
      if (wr_op && breq.addr == `MESC_OFS_EN) begin
         next_st.enable = breq.wdata[`MESC_NCNT-1:0];
      end
      if (wr_op && breq.addr == `MESC_OFS_CTRL) begin
         next_st.duplex = breq.wdata[`MESC_CTRL_DUPLEX];
         next_st.rx_en = breq.wdata[`MESC_CTRL_RXEN];
         next_st.stat_we = breq.wdata[`MESC_CTRL_STWE];
         next_st.big_frames = breq.wdata[`MESC_CTRL_BIG];
      end
      // Sticky events; a new event wins over a clear in the same cycle
      if (wr_op && breq.addr == `MESC_OFS_CLR) begin
         next_st.status = (st.status & ~breq.wdata[`MESC_NCNT-1:0]) | inc;
      end else begin
         next_st.status = st.status | inc;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign collision_credit = st.col_pulse;
   assign irq = |(st.status & st.enable);
endmodule : mesc_stat_counters

// ===== mesc_mac_model.sv
// Behavioural model of the MAC datapath that hands frame reports to the counters
`timescale 1ns/1ps
module mesc_mac_model
   import mesc_pkg::*;
(
   // Clock and reset
   input logic core_clk,
   input logic rst,
   // Commands from the bench
   input logic go,
   input mesc_rx_rpt_s rx_in,
   input mesc_tx_rpt_s tx_in,
   // Reports toward the counters
   output mesc_rx_rpt_s rx_rpt,
   output mesc_tx_rpt_s tx_rpt
);
   // Between reports the fields keep toggling so stale values are never trusted
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         rx_rpt <= '0;
         tx_rpt <= '0;
      end else if (go) begin
         rx_rpt <= rx_in;
         tx_rpt <= tx_in;
      end else begin
         rx_rpt <= {1'b0, ~rx_rpt[$bits(rx_rpt)-2:0]};
         tx_rpt <= {1'b0, ~tx_rpt[$bits(tx_rpt)-2:0]};
      end
   end
endmodule : mesc_mac_model

// ===== mesc_stat_counters_checker.sv
// Port checks of bus timing, read data and collision credit
`timescale 1ns/1ps
module mesc_stat_counters_checker
   import mesc_pkg::*;
(
   // Clock and reset
   input logic core_clk,
   input logic rst,
   // Bus
   input logic hsel,
   input logic [1:0] htrans,
   input logic hready,
   input logic hreadyout,
   input logic hresp,
   input logic [31:0] hrdata,
   // Reports and credit
   input mesc_tx_rpt_s tx_rpt,
   input logic collision_credit
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_taken;
      hsel && htrans[1] && hready && hreadyout;
   endsequence
   sequence s_late;
      tx_rpt.done && tx_rpt.late_col && !tx_rpt.underrun;
   endsequence
   property p_wait;
      s_taken |=> !hreadyout ##1 hreadyout;
   endproperty
   property p_one_wait;
      !hreadyout |=> hreadyout;
   endproperty
   property p_okay;
      !hresp;
   endproperty
   property p_upper;
      hreadyout |-> hrdata[31:16] == 16'h0;
   endproperty
   property p_hold;
      hreadyout && $past(hreadyout) |-> $stable(hrdata);
   endproperty
   property p_credit;
      s_late |=> collision_credit;
   endproperty
   property p_cause;
      collision_credit |-> $past(tx_rpt.done) && $past(tx_rpt.late_col) && !$past(tx_rpt.underrun);
   endproperty
   property p_quiet;
      tx_rpt.done && tx_rpt.underrun |=> !collision_credit;
   endproperty
   a_wait: assert property (p_wait) else $error("wait state wrong");
   a_one_wait: assert property (p_one_wait) else $error("wait too long");
   a_okay: assert property (p_okay) else $error("response not okay");
   a_upper: assert property (p_upper) else $error("upper bits set");
   a_hold: assert property (p_hold) else $error("read data moved");
   a_credit: assert property (p_credit) else $error("credit missing");
   a_cause: assert property (p_cause) else $error("credit without cause");
   a_quiet: assert property (p_quiet) else $error("credit on underrun");
endmodule : mesc_stat_counters_checker
bind mesc_stat_counters mesc_stat_counters_checker mesc_stat_counters_checker_i (
   .core_clk(core_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hready(hready),
   .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_rpt(tx_rpt),
   .collision_credit(collision_credit));

// ===== mesc_stat_counters_test.sv
// Self-checking bench of the error statistics counters
`timescale 1ns/1ps
module mesc_stat_counters_test
   import mesc_pkg::*;
;
   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic hwrite = 1'b0;
   logic go = 1'b0;
   logic hreadyout, hresp, collision_credit, irq;
   logic [31:0] hrdata, rd;
   mesc_rx_rpt_s rx_in = '0;
   mesc_tx_rpt_s tx_in = '0;
   mesc_rx_rpt_s rx_rpt;
   mesc_tx_rpt_s tx_rpt;
   logic [31:0] rnd = 32'h3b6edda6;
   logic [8:0] ctrl;
   logic [15:0] cnt [8];
   logic [10:0] lens [8] = '{11'd63, 11'd64, 11'd100, 11'd1517, 11'd1518, 11'd1519,
      11'd1536, 11'd1537};
   int fail_count = 0;
   int compares = 0;

   mesc_stat_counters mesc_stat_counters_i (.core_clk(core_clk), .rst(rst), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .rx_rpt(rx_rpt), .tx_rpt(tx_rpt), .collision_credit(collision_credit), .irq(irq));
   mesc_mac_model mesc_mac_model_i (.core_clk(core_clk), .rst(rst), .go(go), .rx_in(rx_in),
      .tx_in(tx_in), .rx_rpt(rx_rpt), .tx_rpt(tx_rpt));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   function automatic logic [15:0] wmask(input int i);
      return (i == 1 || i == 6) ? 16'hffff : 16'h00ff;
   endfunction : wmask

   function automatic logic [7:0] frame_events(input mesc_rx_rpt_s r, input mesc_tx_rpt_s t,
      input logic [8:0] c);
      logic [7:0] e;
      e = 8'h0;
      if (c[3]) begin
         e[0] = r.len_odd && (r.crc_bad || r.symbol_err) && r.len >= 11'd64 &&
            r.len <= (c[8] ? 11'd1536 : 11'd1518);
         e[6] = r.addr_match && r.no_buffer;
         e[7] = r.addr_match && r.overrun;
      end
      e[4] = t.underrun;
      if (!t.underrun) begin
         e[1] = t.deferred && t.collisions == 5'h0;
         e[2] = t.late_col;
         e[3] = t.excess_col;
         e[5] = !c[0] && t.collisions == 5'h0 && (!t.crs_seen || t.crs_dropped);
      end
      return e;
   endfunction : frame_events

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus

   task automatic send(input mesc_rx_rpt_s r, input mesc_tx_rpt_s t);
      rx_in <= r;
      tx_in <= t;
      go <= 1'b1;
      @(posedge core_clk);
   endtask : send

   task automatic settle;
      go <= 1'b0;
      repeat (3) @(posedge core_clk);
   endtask : settle

   task automatic stop_test;
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : stop_test

   initial begin
      repeat (20000) @(posedge core_clk);
      fail_count++;
      stop_test();
   end

   initial begin
      mesc_rx_rpt_s r;
      mesc_tx_rpt_s t;
      logic [7:0] e;
      repeat (16) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      for (int a = 0; a <= 8'h30; a += 4) begin
         bus(1'b0, 8'(a), 32'h0);
         check(rd, 32'h0);
      end
      bus(1'b1, 8'h00, 32'hff);
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'h0);
      bus(1'b1, 8'h2c, 32'h88);
      for (int i = 0; i < 8; i++) begin
         bus(1'b1, 8'(i * 4), 32'hffffffff);
         bus(1'b0, 8'(i * 4), 32'h0);
         check(rd, {16'h0, wmask(i)});
         bus(1'b0, 8'(i * 4), 32'h0);
         check(rd, 32'h0);
      end
      bus(1'b1, 8'h00, 32'hfe);
      bus(1'b1, 8'h04, 32'hfffe);
      r = '0;
      r.done = 1'b1;
      r.len_odd = 1'b1;
      r.crc_bad = 1'b1;
      r.len = 11'd100;
      t = '0;
      t.done = 1'b1;
      t.deferred = 1'b1;
      t.crs_seen = 1'b1;
      repeat (3) send(r, t);
      settle();
      bus(1'b0, 8'h00, 32'h0);
      check(rd, 32'hff);
      bus(1'b0, 8'h04, 32'h0);
      check(rd, 32'hffff);
      for (int m = 0; m < 4; m++) begin
         ctrl = {m == 3, 1'b1, 3'h0, m[1], 2'h0, m[0]};
         bus(1'b1, 8'h2c, {23'h0, ctrl});
         for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            cnt[i] = 16'h0;
         end
         repeat (40) begin
            rnd = lfsr(rnd);
            r = rnd[17:0];
            r.done = 1'b1;
            r.len = lens[rnd[31:29]];
            rnd = lfsr(rnd);
            t = rnd[11:0];
            t.done = 1'b1;
            t.collisions = {3'h0, rnd[13:12]} | {4'h0, t.late_col};
            if (t.excess_col) begin
               t.collisions = 5'd16;
            end
            e = frame_events(r, t, ctrl);
            for (int i = 0; i < 8; i++) begin
               cnt[i] = cnt[i] + {15'h0, e[i]};
            end
            send(r, t);
         end
         settle();
         for (int i = 0; i < 8; i++) begin
            bus(1'b0, 8'(i * 4), 32'h0);
            check(rd, {16'h0, cnt[i]});
         end
      end
      bus(1'b1, 8'h28, 32'h0);
      bus(1'b1, 8'h24, 32'hff);
      r = '0;
      t = '0;
      t.done = 1'b1;
      t.underrun = 1'b1;
      send(r, t);
      settle();
      check({31'h0, irq}, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'h10);
      bus(1'b1, 8'h28, 32'h10);
      @(posedge core_clk);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, 8'h24, 32'h10);
      @(posedge core_clk);
      check({31'h0, irq}, 32'h0);
      bus(1'b0, 8'h20, 32'h0);
      check(rd, 32'h0);
      stop_test();
   end
endmodule : mesc_stat_counters_test
